// [ast_pkg.sv]
// Constants, types and helpers of the asynchronous serial transceiver
// Summary of operation
// - Writing the data register starts a transmission
// - Load at once when idle, else once stop bit is on line
// - Empty flag set on load, held until written
// - Load clears start bit, sets stop bit
// - Nine-bit mode copies ninth bit at load
// - Start bit on next tick, then LSB first
// - Complete flag after stop held one bit
// - Transmit enable takes and drives pin one
// - Receiver samples at sixteen times baud
// - Start vote on samples 8-10 rejects noise
// - Data bits by majority of samples 8-10
// - Stop majority zero sets framing error
// - Character transferred if last one read, complete flag set
// - Shared address: read receive, write transmit
// - Ninth received bit stored at transfer
// - Unread data loses new byte, buffered overrun
// - Receive enable forces pin zero input
// - Three separate interrupt request outputs
// - Reading received data clears complete flag
// - Complete flag cleared by vector or one
// - Double speed divides by eight, not sixteen
// - Good stop bit clears framing error
package ast_pkg;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] ADR_DATA    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_CONTROL = 8'h08;
  localparam logic [7:0] ADR_BAUD    = 8'h0c;

  localparam int ST_RXC  = 7;
  localparam int ST_TXC  = 6;
  localparam int ST_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int ST_FE   = 4;
  localparam int ST_OVR  = 3;
  localparam int ST_DBL  = 1;

  localparam int CT_RXIE = 7;
  localparam int CT_TXIE = 6;
  localparam int CT_UDIE = 5;
  localparam int CT_RECEIVER_ENABLE = 4;
  localparam int CT_TRANSMITTER_ENABLE = 3;
  localparam int CT_NINE = 2;
  localparam int CT_RX9  = 1;
  localparam int CT_TX9  = 0;

  localparam logic [11:0] BAUD_RESET = 12'h00a;

  // ----------------------------------------
  // Framing and sampling counts
  // ----------------------------------------
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [3:0] FRAME_8    = 4'ha;
  localparam logic [3:0] FRAME_9    = 4'hb;
  localparam logic [3:0] BITS_8     = 4'h8;
  localparam logic [3:0] BITS_9     = 4'h9;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ast_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ast_wb_rsp_t;

  typedef struct packed {
    logic out;
    logic dir;
  } ast_gpio_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;

  // Two of three vote
  function automatic logic ast_maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

endpackage

// [ast_uart.sv]
// Asynchronous serial transceiver with Wishbone register slave
`timescale 1ns/100ps
module ast_uart (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire ast_pkg::ast_wb_req_t wbReq,
  output      ast_pkg::ast_wb_rsp_t wbRsp,
  input  wire logic                txcVectorAck,
  input  wire ast_pkg::ast_gpio_t  pinOneGpio,
  input  wire ast_pkg::ast_gpio_t  pinZeroGpio,
  input  wire logic                pinZeroPullupCtl,
  input  wire logic                pinZeroIn,
  output      logic                pinOneOut,
  output      logic                pinOneOe,
  output      logic                pinZeroOut,
  output      logic                pinZeroOe,
  output      logic                pinZeroPullup,
  output      logic                irqRxComplete,
  output      logic                irqTxComplete,
  output      logic                irqHoldEmpty
);
  import ast_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic          rx_complete_flag;
  logic          tx_complete_flag;
  logic          tx_holding_empty_flag;
  logic          fe;
  logic          ovr;
  logic          ovrPending;
  logic          dbl;
  logic [7:0]    ctrl;
  logic          rxNinth;
  logic [11:0]   baudDiv;
  logic [11:0]   baudCnt;
  logic          sampleTick;
  logic [4:0]    txSub;
  logic [4:0]    spb;
  logic          bitTick;
  logic [7:0]    txHold;
  logic [10:0]   txShift;
  logic [3:0]    txCount;
  logic          txStopOnLine;
  logic          txLine;
  logic          txLoad;
  logic          txcSet;
  logic          rxSync1;
  logic          rxIn;
  ast_rx_state_t rxState;
  logic [4:0]    rxSample;
  logic [4:0]    next_sample;
  logic [1:0]    votes;
  logic [8:0]    rxShift;
  logic [3:0]    rxBitIdx;
  logic [7:0]    rxData;
  logic          decideNow;
  logic          bitVal;
  logic          rxDone;
  logic          rxUnread;
  logic [7:0]    rxFinal;
  logic          req;
  logic          wrData;
  logic          rdData;
  logic          wrStatus;
  logic          wrCtrl;
  logic          wrBaudLo;
  logic          wrBaudHi;
  logic [31:0]   readData;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One access per request, acted on in its first cycle
  assign req      = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
  assign wrData   = req & wbReq.we & wbReq.sel[0] & (wbReq.adr == ADR_DATA);
  assign rdData   = req & ~wbReq.we & (wbReq.adr == ADR_DATA);
  assign wrStatus = req & wbReq.we & wbReq.sel[0] & (wbReq.adr == ADR_STATUS);
  assign wrCtrl   = req & wbReq.we & wbReq.sel[0] & (wbReq.adr == ADR_CONTROL);
  assign wrBaudLo = req & wbReq.we & wbReq.sel[0] & (wbReq.adr == ADR_BAUD);
  assign wrBaudHi = req & wbReq.we & wbReq.sel[1] & (wbReq.adr == ADR_BAUD);

  // Read mux, unmapped reads zero
  always_comb begin
    readData = 32'h0000_0000;
    if (wbReq.adr == ADR_DATA) begin
      readData[7:0] = rxData;
    end else if (wbReq.adr == ADR_STATUS) begin
      readData[ST_RXC]  = rx_complete_flag;
      readData[ST_TXC]  = tx_complete_flag;
      readData[ST_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
      readData[ST_FE]   = fe;
      readData[ST_OVR]  = ovr;
      readData[ST_DBL]  = dbl;
    end else if (wbReq.adr == ADR_CONTROL) begin
      readData[7:0]  = ctrl;
      readData[CT_RX9] = rxNinth;
      readData[CT_TX9] = 1'b0;
    end else if (wbReq.adr == ADR_BAUD) begin
      readData[11:0] = baudDiv;
    end
  end

  // Acknowledge one cycle after request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= req;
      wbRsp.dat <= req ? readData : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Control, speed and divisor
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl    <= 8'h00;
      dbl     <= 1'b0;
      baudDiv <= BAUD_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl <= wbReq.dat[7:0];
      end
      if (wrStatus) begin
        dbl <= wbReq.dat[ST_DBL];
      end
      if (wrBaudLo) begin
        baudDiv[7:0] <= wbReq.dat[7:0];
      end
      if (wrBaudHi) begin
        baudDiv[11:8] <= wbReq.dat[11:8];
      end
    end
  end

  // ----------------------------------------
  // Baud generation
  // ----------------------------------------
  assign spb        = dbl ? SPB_DOUBLE : SPB_NORMAL;
  // Compare by magnitude so a divisor lowered below the count cannot stall ticks
  assign sampleTick = (baudCnt >= baudDiv);
  assign bitTick    = sampleTick & (txSub == spb - 5'h01);

  // Sample rate divider and bit divider
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      baudCnt <= 12'h000;
      txSub   <= 5'h00;
    end else begin
      baudCnt <= sampleTick ? 12'h000 : baudCnt + 12'h001;
      if (sampleTick) begin
        txSub <= (txSub >= spb - 5'h01) ? 5'h00 : txSub + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // Load when holding full and shifter drained
  assign txLoad = ~tx_holding_empty_flag & (txCount == 4'h0) & ctrl[CT_TRANSMITTER_ENABLE];
  assign txcSet = bitTick & (txCount == 4'h0) & txStopOnLine & tx_holding_empty_flag;

  // Holding register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txHold <= 8'h00;
      tx_holding_empty_flag   <= 1'b1;
    end else begin
      if (wrData) begin
        txHold <= wbReq.dat[7:0];
      end
      tx_holding_empty_flag <= (tx_holding_empty_flag | txLoad) & ~wrData;
    end
  end

  // Shift engine and line
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txShift      <= 11'h7ff;
      txCount      <= 4'h0;
      txStopOnLine <= 1'b0;
      txLine       <= 1'b1;
    end else if (txLoad) begin
      txShift      <= {1'b1, ctrl[CT_NINE] ? ctrl[CT_TX9] : 1'b1, txHold, 1'b0};
      txCount      <= ctrl[CT_NINE] ? FRAME_9 : FRAME_8;
      txStopOnLine <= 1'b0;
    end else if (bitTick) begin
      if (txCount != 4'h0) begin
        txLine       <= txShift[0];
        txShift      <= {1'b1, txShift[10:1]};
        txCount      <= txCount - 4'h1;
        txStopOnLine <= (txCount == 4'h1);
      end else begin
        txLine       <= 1'b1;
        txStopOnLine <= 1'b0;
      end
    end
  end

  // Transmit complete flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_complete_flag <= 1'b0;
    end else begin
      tx_complete_flag <= txcSet | (tx_complete_flag & ~(txcVectorAck | (wrStatus & wbReq.dat[ST_TXC])));
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Pin synchroniser
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxSync1 <= 1'b1;
      rxIn    <= 1'b1;
    end else begin
      rxSync1 <= pinZeroIn;
      rxIn    <= rxSync1;
    end
  end

  assign next_sample = (rxSample == spb) ? 5'h01 : rxSample + 5'h01;
  assign decideNow   = sampleTick & (rxState != RX_IDLE) & (next_sample == (spb >> 1) + 5'h02);
  assign bitVal      = ast_maj3({votes, rxIn});
  assign rxDone      = decideNow & (rxState == RX_STOP);
  assign rxUnread    = rx_complete_flag & ~rdData;
  assign rxFinal     = ctrl[CT_NINE] ? rxShift[7:0] : rxShift[8:1];

  // Bit sampler and framer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxState  <= RX_IDLE;
      rxSample <= 5'h00;
      votes    <= 2'b11;
      rxShift  <= 9'h000;
      rxBitIdx <= 4'h0;
    end else if (!ctrl[CT_RECEIVER_ENABLE]) begin
      rxState <= RX_IDLE;
    end else if (sampleTick) begin
      case (rxState)
        RX_IDLE: begin
          if (!rxIn) begin
            rxSample <= 5'h01;
            rxState  <= RX_START;
          end
        end
        default: begin
          rxSample <= next_sample;
          if ((next_sample == spb >> 1) || (next_sample == (spb >> 1) + 5'h01)) begin
            votes <= {votes[0], rxIn};
          end
          if (decideNow) begin
            case (rxState)
              RX_START: begin
                rxState  <= bitVal ? RX_IDLE : RX_DATA;
                rxBitIdx <= 4'h0;
              end
              RX_DATA: begin
                rxShift  <= {bitVal, rxShift[8:1]};
                rxBitIdx <= rxBitIdx + 4'h1;
                if (rxBitIdx == (ctrl[CT_NINE] ? BITS_9 : BITS_8) - 4'h1) begin
                  rxState <= RX_STOP;
                end
              end
              default: begin
                rxState <= RX_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Receive data, flags and overrun
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxData     <= 8'h00;
      rxNinth    <= 1'b1;
      rx_complete_flag        <= 1'b0;
      fe         <= 1'b0;
      ovr        <= 1'b0;
      ovrPending <= 1'b0;
    end else begin
      if (rxDone && !rxUnread) begin
        rxData  <= rxFinal;
        rx_complete_flag     <= 1'b1;
        fe      <= ~bitVal;
        ovr     <= 1'b0;
        if (ctrl[CT_NINE]) begin
          rxNinth <= rxShift[8];
        end
      end else if (rdData) begin
        rx_complete_flag <= 1'b0;
      end
      if (rxDone && rxUnread) begin
        ovrPending <= 1'b1;
      end else if (rdData && ovrPending) begin
        ovr        <= 1'b1;
        ovrPending <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pins and interrupt requests
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pinOneOut     <= 1'b1;
      pinOneOe      <= 1'b0;
      pinZeroOut    <= 1'b0;
      pinZeroOe     <= 1'b0;
      pinZeroPullup <= 1'b0;
      irqRxComplete <= 1'b0;
      irqTxComplete <= 1'b0;
      irqHoldEmpty  <= 1'b0;
    end else begin
      pinOneOut     <= ctrl[CT_TRANSMITTER_ENABLE] ? txLine : pinOneGpio.out;
      pinOneOe      <= ctrl[CT_TRANSMITTER_ENABLE] | pinOneGpio.dir;
      pinZeroOut    <= pinZeroGpio.out;
      pinZeroOe     <= ~ctrl[CT_RECEIVER_ENABLE] & pinZeroGpio.dir;
      pinZeroPullup <= pinZeroPullupCtl;
      irqRxComplete <= rx_complete_flag & ctrl[CT_RXIE];
      irqTxComplete <= tx_complete_flag & ctrl[CT_TXIE];
      irqHoldEmpty  <= tx_holding_empty_flag & ctrl[CT_UDIE];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  hold_empty_load_a: assert property (txLoad && !wrData |=> tx_holding_empty_flag)
    else $error("empty flag not set on load");
  hold_write_clear_a: assert property (wrData |=> !tx_holding_empty_flag ##1 (!tx_holding_empty_flag || $past(txLoad)))
    else $error("write did not fill holding register");
  start_bit_first_a: assert property (bitTick && txCount != 0 && txShift[0] == 1'b0 |=> !txLine)
    else $error("start bit not driven low");
  stop_bit_high_a: assert property (bitTick && txCount == 4'h1 && !txLoad |=> txLine && txStopOnLine)
    else $error("stop bit not high");
  tx_complete_set_a: assert property (txcSet |=> tx_complete_flag)
    else $error("transmit complete not set");
  tx_pin_drive_a: assert property (ctrl[CT_TRANSMITTER_ENABLE] |=> pinOneOe && pinOneOut == $past(txLine))
    else $error("transmit pin not driven");
  rx_pin_input_a: assert property (ctrl[CT_RECEIVER_ENABLE] |=> !pinZeroOe)
    else $error("receive pin not forced input");
  frame_error_a: assert property (rxDone && !rxUnread |=> rx_complete_flag && fe == !$past(bitVal))
    else $error("framing flag wrong at transfer");
  overrun_keep_a: assert property (rxDone && rxUnread |=> ovrPending && $stable(rxData))
    else $error("overrun did not keep pending byte");
  read_clears_rxc_a: assert property (rdData && !rxDone |=> !rx_complete_flag)
    else $error("read did not clear receive flag");
  start_reject_a: assert property (decideNow && rxState == RX_START && bitVal |=> rxState == RX_IDLE)
    else $error("noisy start not rejected");

  char_sent_c: cover property (txcSet);
  char_recv_c: cover property (rxDone && !rxUnread && bitVal);
  overrun_c: cover property (rxDone && rxUnread);
  back_to_back_c: cover property (txLoad && txStopOnLine);

endmodule

// [ast_peer.sv]
// Far-side serial node model: frame sender and frame receiver
`timescale 1ns/100ps
module ast_peer (
  input  wire logic       clk_sys,
  input  wire logic       nineBits,
  input  wire logic       txLine,
  output      logic       rxLine,
  output      logic       gotChar,
  output      logic [9:0] gotFrame
);
  // ----------------------------------------
  // Sender side
  // ----------------------------------------
  initial begin
    rxLine   = 1'b1;
    gotChar  = 1'b0;
    gotFrame = '0;
  end

  // One frame, sixteen clocks a bit, start low, LSB first
  task automatic send(input logic [8:0] d, input logic stopBit, input logic nine);
    logic [10:0] f;
    f = nine ? {stopBit, d, 1'b0} : {1'b0, stopBit, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clk_sys);
      rxLine <= f[i];
      repeat (15) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rxLine <= 1'b1; // Back to idle after a bad stop too
  endtask

  // Short low glitch, too short to be a start bit
  task automatic spike();
    @(posedge clk_sys);
    rxLine <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rxLine <= 1'b1;
  endtask

  // ----------------------------------------
  // Receiver side
  // ----------------------------------------
  // Samples mid-bit; data bits then stop bit into gotFrame
  always begin
    @(negedge clk_sys);
    if (txLine === 1'b0) begin
      gotFrame = '0;
      repeat (8) @(negedge clk_sys);
      for (int i = 0; i < (nineBits ? 10 : 9); i++) begin
        repeat (16) @(negedge clk_sys);
        gotFrame[i] = txLine;
      end
      @(posedge clk_sys);
      gotChar <= 1'b1;
      @(posedge clk_sys);
      gotChar <= 1'b0;
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench of the serial transceiver against a far-side node
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb_top;
  import ast_pkg::*;
  logic        clk_sys;
  logic        arst_n;
  ast_wb_req_t wbReq;
  ast_wb_rsp_t wbRsp;
  logic        txcVectorAck;
  ast_gpio_t   pinOneGpio;
  ast_gpio_t   pinZeroGpio;
  logic        pinZeroPullupCtl;
  logic        pinOneOut;
  logic        pinOneOe;
  logic        pinZeroOut;
  logic        pinZeroOe;
  logic        pinZeroPullup;
  logic        irqRx;
  logic        irqTx;
  logic        irqEmpty;
  logic        peerLine;
  logic        peerNine;
  logic        peerGot;
  logic [9:0]  peerFrame;
  logic        chkRd;
  int          n_mismatch;
  int          cmp_count;
  integer      seed;
  logic [31:0] expRd[$];
  logic [9:0]  expTx[$];
  logic [31:0] expV;
  logic [9:0]  expF;
  logic [31:0] rdv;
  logic [8:0]  d9;
  logic        rx9;

  // Wire levels: receive pin shared with gpio drive, transmit pin pulled up
  wire lineIn = pinZeroOe ? pinZeroOut : peerLine;
  wire lineTx = pinOneOe ? pinOneOut : 1'b1;

  ast_uart i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .txcVectorAck(txcVectorAck), .pinOneGpio(pinOneGpio), .pinZeroGpio(pinZeroGpio),
    .pinZeroPullupCtl(pinZeroPullupCtl), .pinZeroIn(lineIn), .pinOneOut(pinOneOut), .pinOneOe(pinOneOe),
    .pinZeroOut(pinZeroOut), .pinZeroOe(pinZeroOe), .pinZeroPullup(pinZeroPullup),
    .irqRxComplete(irqRx), .irqTxComplete(irqTx), .irqHoldEmpty(irqEmpty));
  ast_peer i_peer (.clk_sys(clk_sys), .nineBits(peerNine), .txLine(lineTx), .rxLine(peerLine),
    .gotChar(peerGot), .gotFrame(peerFrame));

  // ----------------------------------------
  // Clock, bus tasks and closing
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Classic single cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic chk,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    chkRd <= chk;
    // Ack and data are taken at the rising edge, request released right after it
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    q = wbRsp.dat;
    wbReq <= '0;
    chkRd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expRd.push_back(e);
    wb(1'b0, a, '0, 1'b1, rdv);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 1'b0, rdv);
  endtask

  // Polls a status bit under a bounded count
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STATUS, '0, 1'b0, rdv);
      n++;
    end while (rdv[b] !== 1'b1 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      $display("unexpected status bit %0d: expected 1 seen %b", b, rdv[b]);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watcher: oldest note against each rd task answer and each line frame
  always @(negedge clk_sys) begin
    if (chkRd && wbRsp.ack === 1'b1) begin
      expV = expRd.pop_front();
      `CHK("read data", expV, wbRsp.dat)
    end
    if (peerGot === 1'b1) begin
      expF = expTx.pop_front();
      `CHK("line frame", expF, peerFrame)
    end
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    $display("unexpected watchdog: expected end seen hang");
    wrap_up();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h96a8;
    arst_n = 1'b0;
    wbReq = '0;
    chkRd = 1'b0;
    txcVectorAck = 1'b0;
    pinOneGpio = '{out: 1'b1, dir: 1'b0};
    pinZeroGpio = '{out: 1'b0, dir: 1'b1};
    pinZeroPullupCtl = 1'b1;
    peerNine = 1'b0;
    rx9 = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk_sys);
    `CHK("tx pin in reset", 1'b1, pinOneOut)
    `CHK("tx oe in reset", 1'b0, pinOneOe)
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADR_STATUS, 32'h20);
    rd(ADR_CONTROL, 32'h02);
    rd(ADR_BAUD, 32'h00a);
    rd(8'h10, 32'h0);
    wr(ADR_BAUD, 32'h0);
    wr(ADR_CONTROL, 32'h18);
    repeat (2) @(negedge clk_sys);
    `CHK("tx oe", 1'b1, pinOneOe)
    `CHK("tx idle", 1'b1, pinOneOut)
    `CHK("rx oe", 1'b0, pinZeroOe)
    `CHK("pull-up", 1'b1, pinZeroPullup)
    $display("test reset and pins done");
    // Back-to-back characters, 8 and 9 bits
    for (int k = 0; k < 6; k++) begin
      d9 = 9'($random(seed));
      peerNine = k[0];
      wr(ADR_CONTROL, {24'h0, 5'b01011, k[0], 1'b0, d9[8]});
      expTx.push_back(k[0] ? {1'b1, d9} : {2'b01, d9[7:0]});
      expTx.push_back(k[0] ? {1'b1, d9[8], ~d9[7:0]} : {2'b01, ~d9[7:0]});
      wr(ADR_DATA, {24'h0, d9[7:0]});
      wr(ADR_DATA, {24'h0, ~d9[7:0]});
      rd(ADR_STATUS, 32'h00);
      poll(ST_TXC);
      rd(ADR_STATUS, 32'h60);
      `CHK("tx irq set", 1'b1, irqTx)
      if (k[0]) begin
        @(posedge clk_sys);
        txcVectorAck <= 1'b1;
        @(posedge clk_sys);
        txcVectorAck <= 1'b0;
      end else begin
        wr(ADR_STATUS, 32'h40);
      end
      rd(ADR_STATUS, 32'h20);
    end
    $display("test transmit done");
    // Reception, 8 and 9 bits
    for (int k = 0; k < 4; k++) begin
      d9 = 9'($random(seed));
      wr(ADR_CONTROL, {24'h0, 5'b10011, k[0], 2'b00});
      i_peer.send(d9, 1'b1, k[0]);
      if (k[0]) rx9 = d9[8];
      poll(ST_RXC);
      rd(ADR_STATUS, 32'ha0);
      `CHK("rx irq set", 1'b1, irqRx)
      rd(ADR_DATA, {24'h0, d9[7:0]});
      rd(ADR_CONTROL, {24'h0, 5'b10011, k[0], rx9, 1'b0});
      rd(ADR_STATUS, 32'h20);
    end
    wr(ADR_CONTROL, 32'h18);
    i_peer.send(d9, 1'b0, 1'b0);
    poll(ST_RXC);
    rd(ADR_STATUS, 32'hb0);
    rd(ADR_DATA, {24'h0, d9[7:0]});
    i_peer.send(~d9, 1'b1, 1'b0);
    poll(ST_RXC);
    rd(ADR_STATUS, 32'ha0);
    rd(ADR_DATA, {24'h0, ~d9[7:0]});
    $display("test receive done");
    // Overrun: second byte lost, flag shows after the read
    i_peer.send(d9, 1'b1, 1'b0);
    i_peer.send(~d9, 1'b1, 1'b0);
    rd(ADR_STATUS, 32'ha0);
    rd(ADR_DATA, {24'h0, d9[7:0]});
    rd(ADR_STATUS, 32'h28);
    i_peer.send(9'h05a, 1'b1, 1'b0);
    poll(ST_RXC);
    rd(ADR_STATUS, 32'ha0);
    rd(ADR_DATA, 32'h5a);
    i_peer.spike();
    repeat (200) @(posedge clk_sys);
    rd(ADR_STATUS, 32'h20);
    $display("test overrun and noise done");
    // Double speed: eight samples a bit, two clocks a sample
    wr(ADR_BAUD, 32'h1);
    wr(ADR_STATUS, 32'h2);
    rd(ADR_STATUS, 32'h22);
    i_peer.send(9'h0c3, 1'b1, 1'b0);
    poll(ST_RXC);
    rd(ADR_DATA, 32'hc3);
    peerNine = 1'b0;
    expTx.push_back(10'h13c);
    wr(ADR_DATA, 32'h3c);
    poll(ST_TXC);
    wr(ADR_STATUS, 32'h40);
    $display("test double speed done");
    wr(ADR_CONTROL, 32'hf8);
    repeat (2) @(negedge clk_sys);
    `CHK("empty irq", 1'b1, irqEmpty)
    `CHK("rx irq", 1'b0, irqRx)
    `CHK("tx irq", 1'b0, irqTx)
    wr(ADR_CONTROL, 32'h00);
    repeat (2) @(negedge clk_sys);
    `CHK("rx pin oe", 1'b1, pinZeroOe)
    `CHK("tx pin oe", 1'b0, pinOneOe)
    `CHK("tx pin gpio", 1'b1, pinOneOut)
    `CHK("rx pin gpio", 1'b0, pinZeroOut)
    `CHK("frames left", 0, expTx.size())
    $display("test irq and release done");
    wrap_up();
  end
endmodule
